// ### core/mmtu_pkg.sv
// Package for the multi-mode timer unit: register map, fields, modes, resets.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock.
package mmtu_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFFS    = 8'h00;
    localparam logic [7:0] CT_CFG_OFFS  = 8'h04;
    localparam logic [7:0] CT_PER_OFFS  = 8'h08;
    localparam logic [7:0] CT_CNT_OFFS  = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFFS = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFFS = 8'h14;
    localparam logic [7:0] IRQ_EN_OFFS  = 8'h18;
    localparam logic [7:0] GPT_BASE     = 8'h20;
    localparam logic [7:0] GPT_STRIDE   = 8'h10;
    localparam logic [3:0] GP_CFG_OFFS  = 4'h0;
    localparam logic [3:0] GP_CNT_OFFS  = 4'h4;
    localparam logic [3:0] GP_PER_OFFS  = 4'h8;
    localparam logic [3:0] GP_WID_OFFS  = 4'hc;

    // ****************************************
    // Fields
    // ****************************************
    localparam int NUM_GPT     = 3;
    localparam int CFG_W       = 6;
    localparam int CTRL_STAT_POS = 8;
    localparam int IRQ_CT_POS  = 3;
    localparam int IRQ_W       = 4;
    localparam int CT_EN_POS   = 0;
    localparam int CT_PIN_POS  = 1;
    localparam int CFG_IRQEN_POS = 2;
    localparam int CFG_POL_POS = 3;

    localparam logic [1:0] MODE_PWM  = 2'h1;
    localparam logic [1:0] MODE_CAP  = 2'h2;
    localparam logic [1:0] MODE_WDOG = 2'h3;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic [31:0]      cnt;
        logic [31:0]      per;
        logic [31:0]      wid;
    } mmtu_gpt_regs_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_WRSP = 3'h2,
        BUS_RRSP = 3'h4
    } mmtu_bus_state_t;

endpackage

// ### core/mmtu_top.sv
// Multi-mode timer unit: core timer plus three general-purpose timers.
// Assumes AXI4-Lite master on the register side and synchronous pin inputs.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps

module mmtu_top (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    input  wire logic [2:0]  tmr_pin_i,
    output logic [2:0]       tmr_pin_o,
    output logic [2:0]       tmr_pin_oe_o,
    output logic             core_timer_expiry_pin_o,
    output logic             irq_o
);

    // ****************************************
    // Bus slave
    // ****************************************
    mmtu_pkg::mmtu_bus_state_t bus_q;
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;
    assign rd_go = (bus_q == mmtu_pkg::BUS_IDLE) && arvalid_i && arready_o;
    assign wr_go = (bus_q == mmtu_pkg::BUS_IDLE) && aw_have_q && w_have_q && !rd_go;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 8'h00;
            w_q       <= mmtu_pkg::RST_WORD;
            ws_q      <= 4'h0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
        end else begin
            awready_o <= !aw_have_q && !(awvalid_i && awready_o) && (bus_q == mmtu_pkg::BUS_IDLE);
            wready_o  <= !w_have_q && !(wvalid_i && wready_o) && (bus_q == mmtu_pkg::BUS_IDLE);
            if (awvalid_i && awready_o) aw_q <= awaddr_i;
            if (awvalid_i && awready_o) aw_have_q <= 1'b1;
            else if (wr_go) aw_have_q <= 1'b0;
            if (wvalid_i && wready_o) w_q <= wdata_i;
            if (wvalid_i && wready_o) ws_q <= wstrb_i;
            if (wvalid_i && wready_o) w_have_q <= 1'b1;
            else if (wr_go) w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bus_q     <= mmtu_pkg::BUS_IDLE;
            bvalid_o  <= 1'b0;
            bresp_o   <= mmtu_pkg::RESP_OKAY;
            rvalid_o  <= 1'b0;
            rresp_o   <= mmtu_pkg::RESP_OKAY;
            rdata_o   <= mmtu_pkg::RST_WORD;
            arready_o <= 1'b0;
        end else begin
            arready_o <= (bus_q == mmtu_pkg::BUS_IDLE) && !arready_o && !wr_go;
            unique case (bus_q)
                mmtu_pkg::BUS_IDLE: begin
                    if (wr_go) begin
                        bvalid_o <= 1'b1;
                        bresp_o  <= wr_ok ? mmtu_pkg::RESP_OKAY : mmtu_pkg::RESP_SLVERR;
                        bus_q    <= mmtu_pkg::BUS_WRSP;
                    end else if (rd_go) begin
                        rvalid_o <= 1'b1;
                        rdata_o  <= rd_val;
                        rresp_o  <= rd_ok ? mmtu_pkg::RESP_OKAY : mmtu_pkg::RESP_SLVERR;
                        bus_q    <= mmtu_pkg::BUS_RRSP;
                    end
                end
                mmtu_pkg::BUS_WRSP: if (bready_i) begin
                    bvalid_o <= 1'b0;
                    bus_q    <= mmtu_pkg::BUS_IDLE;
                end
                mmtu_pkg::BUS_RRSP: if (rready_i) begin
                    rvalid_o <= 1'b0;
                    bus_q    <= mmtu_pkg::BUS_IDLE;
                end
                default: bus_q <= mmtu_pkg::BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // Registers and timers
    // ****************************************
    logic [2:0]  gp_en_q;
    logic [2:0]  gp_stat_q;
    logic [1:0]  ct_cfg_q;
    logic [31:0] ct_per_q;
    logic [31:0] ct_cnt_q;
    logic [3:0]  irq_stat_q;
    logic [3:0]  irq_en_q;
    logic [3:0]  irq_clr;
    logic [3:0]  ev;
    mmtu_pkg::mmtu_gpt_regs_t gp_q [3];
    logic [2:0]  pin_d1_q;
    logic        ct_hit;
    logic [3:0]  irq_en_d;
    logic        wr_ctrl;
    logic        wr_ctcfg;
    logic        wr_ctper;
    assign wr_ctrl  = wr_go && aw_q == mmtu_pkg::CTRL_OFFS && ws_q[0];
    assign wr_ctcfg = wr_go && aw_q == mmtu_pkg::CT_CFG_OFFS && ws_q[0];
    assign wr_ctper = wr_go && aw_q == mmtu_pkg::CT_PER_OFFS && ws_q == 4'hf;
    assign irq_clr  = (wr_go && aw_q == mmtu_pkg::IRQ_CLR_OFFS) ? w_q[3:0] : 4'h0;
    assign ct_hit   = ct_cfg_q[mmtu_pkg::CT_EN_POS] && ct_cnt_q >= ct_per_q;
    assign irq_en_d = (wr_go && aw_q == mmtu_pkg::IRQ_EN_OFFS && ws_q[0]) ? w_q[3:0] : irq_en_q;
    // Core timer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ct_cfg_q <= 2'h0;
            ct_per_q <= mmtu_pkg::RST_WORD;
            ct_cnt_q <= mmtu_pkg::RST_WORD;
            core_timer_expiry_pin_o <= 1'b0;
        end else begin
            if (wr_ctcfg) ct_cfg_q <= w_q[1:0];
            if (wr_ctper) ct_per_q <= w_q;
            ct_cnt_q <= (ct_hit || !ct_cfg_q[mmtu_pkg::CT_EN_POS]) ? mmtu_pkg::RST_WORD
                                                                    : ct_cnt_q + 32'h1;
            core_timer_expiry_pin_o <= ct_hit && ct_cfg_q[mmtu_pkg::CT_PIN_POS];
        end
    end

    // Shared control: enables and sticky status, set wins over clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gp_en_q   <= 3'h0;
            gp_stat_q <= 3'h0;
        end else begin
            if (wr_ctrl) gp_en_q <= w_q[2:0];
            gp_stat_q <= (gp_stat_q & ~(wr_ctrl ? w_q[10:8] : 3'h0)) | ev[2:0];
        end
    end

    // Interrupt status, enable and clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_stat_q <= 4'h0;
            irq_en_q   <= 4'h0;
            irq_o      <= 1'b0;
        end else begin
            irq_en_q   <= irq_en_d;
            irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
            irq_o      <= |(((irq_stat_q & ~irq_clr) | ev) & irq_en_d);
        end
    end

    assign ev[mmtu_pkg::IRQ_CT_POS] = ct_hit;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) pin_d1_q <= 3'h0;
        else pin_d1_q <= tmr_pin_i;
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_gpt
            logic [7:0] base;
            logic [1:0] mode;
            logic       gwr;
            logic       wrap;
            logic       fall;
            logic       rise;
            assign base = 8'(mmtu_pkg::GPT_BASE + mmtu_pkg::GPT_STRIDE * g);
            assign gwr  = wr_go && aw_q[7:4] == base[7:4] && ws_q == 4'hf;
            assign mode = gp_q[g].cfg[1:0];
            assign rise = tmr_pin_i[g] && !pin_d1_q[g];
            assign fall = !tmr_pin_i[g] && pin_d1_q[g];
            assign wrap = gp_q[g].cnt >= gp_q[g].per;
            assign ev[g] = gp_en_q[g] && gp_q[g].cfg[mmtu_pkg::CFG_IRQEN_POS]
                           && ((mode == mmtu_pkg::MODE_PWM && wrap)
                               || (mode == mmtu_pkg::MODE_CAP && fall)
                               || (mode == mmtu_pkg::MODE_WDOG && wrap && !rise));
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    gp_q[g] <= '0;
                    tmr_pin_o[g]    <= 1'b0;
                    tmr_pin_oe_o[g] <= 1'b0;
                end else begin
                    if (gwr && aw_q[3:0] == mmtu_pkg::GP_CFG_OFFS)
                        gp_q[g].cfg <= w_q[mmtu_pkg::CFG_W-1:0];
                    if (gwr && aw_q[3:0] == mmtu_pkg::GP_PER_OFFS) gp_q[g].per <= w_q;
                    tmr_pin_oe_o[g] <= gp_en_q[g] && mode == mmtu_pkg::MODE_PWM;
                    if (!gp_en_q[g]) begin
                        gp_q[g].cnt  <= mmtu_pkg::RST_WORD;
                        tmr_pin_o[g] <= 1'b0;
                        if (gwr && aw_q[3:0] == mmtu_pkg::GP_WID_OFFS) gp_q[g].wid <= w_q;
                    end else begin
                        unique case (mode)
                            mmtu_pkg::MODE_PWM: begin
                                if (gwr && aw_q[3:0] == mmtu_pkg::GP_WID_OFFS)
                                    gp_q[g].wid <= w_q;
                                gp_q[g].cnt  <= wrap ? mmtu_pkg::RST_WORD
                                                     : gp_q[g].cnt + 32'h1;
                                tmr_pin_o[g] <= (gp_q[g].cnt < gp_q[g].wid)
                                                ^ gp_q[g].cfg[mmtu_pkg::CFG_POL_POS];
                            end
                            mmtu_pkg::MODE_CAP: begin
                                if (rise) gp_q[g].cnt <= 32'h1;
                                else if (tmr_pin_i[g]) gp_q[g].cnt <= gp_q[g].cnt + 32'h1;
                                if (fall) gp_q[g].wid <= gp_q[g].cnt;
                            end
                            mmtu_pkg::MODE_WDOG: begin
                                if (gwr && aw_q[3:0] == mmtu_pkg::GP_WID_OFFS)
                                    gp_q[g].wid <= w_q;
                                gp_q[g].cnt <= (rise || wrap) ? mmtu_pkg::RST_WORD
                                                              : gp_q[g].cnt + 32'h1;
                            end
                            default: gp_q[g].cnt <= mmtu_pkg::RST_WORD;
                        endcase
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_val = mmtu_pkg::RST_WORD;
        rd_ok  = 1'b1;
        if (araddr_i >= mmtu_pkg::GPT_BASE && araddr_i < 8'h50 && araddr_i[1:0] == 2'h0) begin
            unique case (araddr_i[3:0])
                mmtu_pkg::GP_CFG_OFFS: rd_val = {26'h0, gp_q[araddr_i[5:4] - 2'h2].cfg};
                mmtu_pkg::GP_CNT_OFFS: rd_val = gp_q[araddr_i[5:4] - 2'h2].cnt;
                mmtu_pkg::GP_PER_OFFS: rd_val = gp_q[araddr_i[5:4] - 2'h2].per;
                default:               rd_val = gp_q[araddr_i[5:4] - 2'h2].wid;
            endcase
        end else begin
            unique case (araddr_i)
                mmtu_pkg::CTRL_OFFS:     rd_val = {21'h0, gp_stat_q, 5'h0, gp_en_q};
                mmtu_pkg::CT_CFG_OFFS:   rd_val = {30'h0, ct_cfg_q};
                mmtu_pkg::CT_PER_OFFS:   rd_val = ct_per_q;
                mmtu_pkg::CT_CNT_OFFS:   rd_val = ct_cnt_q;
                mmtu_pkg::IRQ_STAT_OFFS: rd_val = {28'h0, irq_stat_q};
                mmtu_pkg::IRQ_CLR_OFFS:  rd_val = mmtu_pkg::RST_WORD;
                mmtu_pkg::IRQ_EN_OFFS:   rd_val = {28'h0, irq_en_q};
                default:                 rd_ok  = 1'b0;
            endcase
        end
    end

    assign wr_ok = (aw_q >= mmtu_pkg::GPT_BASE && aw_q < 8'h50) || aw_q == mmtu_pkg::CTRL_OFFS
                   || aw_q == mmtu_pkg::CT_CFG_OFFS || aw_q == mmtu_pkg::CT_PER_OFFS
                   || aw_q == mmtu_pkg::IRQ_CLR_OFFS || aw_q == mmtu_pkg::IRQ_EN_OFFS;

    // ****************************************
    // Checks
    // ****************************************
    property p_ct_wrap;
        @(posedge clk_i) disable iff (reset_i)
        ct_hit |=> ct_cnt_q == 32'h0;
    endproperty
    a_ct_wrap: assert property (p_ct_wrap) else $error("Core count did not wrap");
    property p_ct_pin;
        @(posedge clk_i) disable iff (reset_i)
        core_timer_expiry_pin_o |-> $past(ct_hit) && $past(ct_cfg_q[1]);
    endproperty
    a_ct_pin: assert property (p_ct_pin) else $error("Expiry pin without expiry");
    property p_irq;
        @(posedge clk_i) disable iff (reset_i)
        |(irq_stat_q & irq_en_q) |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("Enabled status without interrupt");
    property p_oe;
        @(posedge clk_i) disable iff (reset_i)
        (gp_en_q[1] && gp_q[1].cfg[1:0] == mmtu_pkg::MODE_CAP) |=> !tmr_pin_oe_o[1];
    endproperty
    a_oe: assert property (p_oe) else $error("Pin driven in capture mode");
    property p_pwm;
        @(posedge clk_i) disable iff (reset_i)
        (gp_en_q[0] && gp_q[0].cfg[1:0] == mmtu_pkg::MODE_PWM && !gp_q[0].cfg[3]
         && gp_q[0].cnt < gp_q[0].wid) |=> tmr_pin_o[0];
    endproperty
    a_pwm: assert property (p_pwm) else $error("Waveform pin low inside width");
    property p_pwm_cnt;
        @(posedge clk_i) disable iff (reset_i)
        (gp_en_q[0] && gp_q[0].cfg[1:0] == mmtu_pkg::MODE_PWM && gp_q[0].cnt < gp_q[0].per)
        |=> gp_q[0].cnt == $past(gp_q[0].cnt) + 32'h1;
    endproperty
    a_pwm_cnt: assert property (p_pwm_cnt) else $error("Waveform count did not step");
    property p_cap;
        @(posedge clk_i) disable iff (reset_i)
        (gp_en_q[1] && gp_q[1].cfg[1:0] == mmtu_pkg::MODE_CAP && !tmr_pin_i[1] && pin_d1_q[1])
        |=> gp_q[1].wid == $past(gp_q[1].cnt);
    endproperty
    a_cap: assert property (p_cap) else $error("Width not captured");
    property p_stat;
        @(posedge clk_i) disable iff (reset_i)
        ev[2] |=> gp_stat_q[2] && irq_stat_q[2];
    endproperty
    a_stat: assert property (p_stat) else $error("Timer event lost");

endmodule

// ### verification/mmtu_pin_model.sv
// External signal sources and loads on the three timer pins.
// Assumes the bench pulses start_i for one cycle to launch a high pulse.
`timescale 1ns/10ps
module mmtu_pin_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] drv_i,
    input  wire logic [2:0] oe_i,
    input  wire logic [2:0] start_i,
    input  wire logic [7:0] len_i,
    output logic      [2:0] pin_o
);
    // ****************************************
    // Pulse sources
    // ****************************************
    logic [7:0] left_q [3];

    always_ff @(posedge clk_i or posedge reset_i) begin
        for (int k = 0; k < 3; k++) begin
            if (reset_i) begin
                left_q[k] <= 8'h00;
            end else if (start_i[k]) begin
                left_q[k] <= len_i;
            end else if (left_q[k] != 8'h00) begin
                left_q[k] <= left_q[k] - 8'h01;
            end
        end
    end

    // ****************************************
    // Wire level, pull-down when nobody drives
    // ****************************************
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            pin_o[k] = oe_i[k] ? drv_i[k] : (left_q[k] != 8'h00);
        end
    end
endmodule

// ### verification/tb_multi_mode_timer_unit.sv
// Self-checking bench for the multi-mode timer unit over AXI4-Lite.
// Assumes mmtu_top, mmtu_pkg and the pin model are compiled first.
`timescale 1ns/10ps
module tb_multi_mode_timer_unit;
    logic        clk_i;
    logic        reset_i;
    logic [7:0]  awaddr_i;
    logic [7:0]  araddr_i;
    logic        awvalid_i;
    logic        wvalid_i;
    logic        bready_i;
    logic        arvalid_i;
    logic        rready_i;
    logic [31:0] wdata_i;
    logic [3:0]  wstrb_i;
    logic        awready_o;
    logic        wready_o;
    logic        bvalid_o;
    logic        arready_o;
    logic        rvalid_o;
    logic [1:0]  bresp_o;
    logic [1:0]  rresp_o;
    logic [31:0] rdata_o;
    logic [2:0]  tmr_pin_i;
    logic [2:0]  tmr_pin_o;
    logic [2:0]  tmr_pin_oe_o;
    logic [2:0]  start_q;
    logic [7:0]  len_q;
    logic        core_timer_expiry_pin_o;
    logic        irq_o;
    logic [1:0]  mon;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          mismatches;
    int          total_checks;
    int          hi;
    int          per;

    assign mon = {core_timer_expiry_pin_o, tmr_pin_o[0]};

    mmtu_top i_mmtu_top (
        .clk_i(clk_i), .reset_i(reset_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
        .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
        .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .tmr_pin_i(tmr_pin_i), .tmr_pin_o(tmr_pin_o), .tmr_pin_oe_o(tmr_pin_oe_o),
        .core_timer_expiry_pin_o(core_timer_expiry_pin_o), .irq_o(irq_o)
    );

    mmtu_pin_model i_mmtu_pin_model (
        .clk_i(clk_i), .reset_i(reset_i), .drv_i(tmr_pin_o), .oe_i(tmr_pin_oe_o),
        .start_i(start_q), .len_i(len_q), .pin_o(tmr_pin_i)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] ga(input int n, input logic [3:0] off);
        ga = mmtu_pkg::GPT_BASE + 8'(n) * mmtu_pkg::GPT_STRIDE + {4'h0, off};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_i);
        awaddr_i  <= a;
        wdata_i   <= d;
        awvalid_i <= 1'b1;
        wvalid_i  <= 1'b1;
        bready_i  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (awvalid_i && awready_o) awvalid_i <= 1'b0;
            if (wvalid_i && wready_o) wvalid_i <= 1'b0;
            if (bvalid_o) break;
        end
        r = bresp_o;
        bready_i <= 1'b0;
        if (i == 100) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_i);
        araddr_i  <= a;
        arvalid_i <= 1'b1;
        rready_i  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (arvalid_i && arready_o) arvalid_i <= 1'b0;
            if (rvalid_o) break;
        end
        d = rdata_o;
        r = rresp_o;
        rready_i <= 1'b0;
        if (i == 100) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, rd, rsp);
        chk(name, rd, exp);
    endtask

    // Measures high time and spacing of rising edges on one monitored line
    task automatic wave(input int s, output int h, output int p);
        int   i;
        int   r1;
        int   r2;
        logic prev;
        logic cur;
        r1 = -1;
        r2 = -1;
        h = 0;
        prev = mon[s];
        for (i = 0; i < 60; i++) begin
            @(posedge clk_i);
            cur = mon[s];
            if (cur && !prev && r1 >= 0 && r2 < 0) r2 = i;
            if (cur && !prev && r1 < 0) r1 = i;
            if (r1 >= 0 && r2 < 0 && cur) h++;
            prev = cur;
        end
        p = r2 - r1;
    endtask

    task automatic pulse(input logic [2:0] which, input logic [7:0] n);
        @(posedge clk_i);
        start_q <= which;
        len_q   <= n;
        @(posedge clk_i);
        start_q <= 3'h0;
    endtask

    // ****************************************
    // Clock and sequence
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        reset_i = 1'b1;
        {awaddr_i, araddr_i, awvalid_i, wvalid_i, bready_i} = '0;
        {arvalid_i, rready_i, wdata_i, start_q, len_q} = '0;
        wstrb_i = 4'hf;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        rchk("ctrl_reset", mmtu_pkg::CTRL_OFFS, 32'h0000_0000);
        rchk("ct_cfg_reset", mmtu_pkg::CT_CFG_OFFS, 32'h0000_0000);
        rchk("gp0_per_reset", ga(0, mmtu_pkg::GP_PER_OFFS), 32'h0000_0000);
        rd_reg(8'h50, rd, rsp);
        chk("rresp_unmapped", {30'h0, rsp}, {30'h0, mmtu_pkg::RESP_SLVERR});
        wr(8'h1c, 32'h0000_0001, rsp);
        chk("bresp_unmapped", {30'h0, rsp}, {30'h0, mmtu_pkg::RESP_SLVERR});
        wr(ga(1, mmtu_pkg::GP_CFG_OFFS), 32'hffff_ffff, rsp);
        rchk("gp1_cfg_width", ga(1, mmtu_pkg::GP_CFG_OFFS), 32'h0000_003f);
        wr(ga(1, mmtu_pkg::GP_PER_OFFS), 32'hffff_ffff, rsp);
        rchk("gp1_per_width", ga(1, mmtu_pkg::GP_PER_OFFS), 32'hffff_ffff);
        // Waveform on timer 0
        wr(ga(0, mmtu_pkg::GP_CFG_OFFS), {30'h1, mmtu_pkg::MODE_PWM}, rsp);
        wr(ga(0, mmtu_pkg::GP_PER_OFFS), 32'h0000_0009, rsp);
        wr(ga(0, mmtu_pkg::GP_WID_OFFS), 32'h0000_0003, rsp);
        wr(mmtu_pkg::CTRL_OFFS, 32'h0000_0001, rsp);
        wave(0, hi, per);
        chk("wave_high", 32'(hi), 32'h0000_0003);
        chk("wave_period", 32'(per), 32'h0000_000a);
        chk("pin_oe_wave", {29'h0, tmr_pin_oe_o}, 32'h0000_0001);
        rchk("irq_stat_gp0", mmtu_pkg::IRQ_STAT_OFFS, 32'h0000_0001);
        chk("irq_masked", {31'h0, irq_o}, 32'h0000_0000);
        wr(mmtu_pkg::IRQ_EN_OFFS, 32'h0000_0001, rsp);
        repeat (2) @(posedge clk_i);
        chk("irq_enabled", {31'h0, irq_o}, 32'h0000_0001);
        // Capture on timer 1 while timer 0 keeps running
        wr(ga(1, mmtu_pkg::GP_CFG_OFFS), {30'h1, mmtu_pkg::MODE_CAP}, rsp);
        wr(mmtu_pkg::CTRL_OFFS, 32'h0000_0003, rsp);
        pulse(3'b010, 8'h07);
        repeat (12) @(posedge clk_i);
        rchk("cap_width", ga(1, mmtu_pkg::GP_WID_OFFS), 32'h0000_0007);
        chk("pin_oe_mixed", {29'h0, tmr_pin_oe_o}, 32'h0000_0001);
        wave(0, hi, per);
        chk("wave_high_kept", 32'(hi), 32'h0000_0003);
        rchk("ctrl_status", mmtu_pkg::CTRL_OFFS, 32'h0000_0303);
        // Watchdog on timer 2
        wr(ga(2, mmtu_pkg::GP_PER_OFFS), 32'h0000_001e, rsp);
        wr(ga(2, mmtu_pkg::GP_CFG_OFFS), {30'h1, mmtu_pkg::MODE_WDOG}, rsp);
        wr(mmtu_pkg::CTRL_OFFS, 32'h0000_0704, rsp);
        // Second write clears a waveform event that raced the first
        wr(mmtu_pkg::CTRL_OFFS, 32'h0000_0704, rsp);
        for (int n = 0; n < 5; n++) begin
            pulse(3'b100, 8'h03);
            repeat (8) @(posedge clk_i);
        end
        rchk("wdog_fed", mmtu_pkg::CTRL_OFFS, 32'h0000_0004);
        repeat (45) @(posedge clk_i);
        rchk("wdog_starved", mmtu_pkg::CTRL_OFFS, 32'h0000_0404);
        wr(mmtu_pkg::CTRL_OFFS, 32'h0000_0700, rsp);
        wr(mmtu_pkg::IRQ_CLR_OFFS, 32'h0000_000f, rsp);
        rchk("irq_cleared", mmtu_pkg::IRQ_STAT_OFFS, 32'h0000_0000);
        chk("irq_low", {31'h0, irq_o}, 32'h0000_0000);
        // Core timer with and without the expiry pin
        wr(mmtu_pkg::CT_PER_OFFS, 32'h0000_0004, rsp);
        wr(mmtu_pkg::CT_CFG_OFFS, 32'h0000_0003, rsp);
        wave(1, hi, per);
        chk("core_period", 32'(per), 32'h0000_0005);
        chk("core_pin_pulse", 32'(hi), 32'h0000_0001);
        rchk("irq_stat_core", mmtu_pkg::IRQ_STAT_OFFS, 32'h0000_0008);
        wr(mmtu_pkg::CT_CFG_OFFS, 32'h0000_0001, rsp);
        wave(1, hi, per);
        chk("core_pin_quiet", 32'(per), 32'h0000_0000);
        test_done();
    end
endmodule
